// ---- rtl/kbd_regs_pkg.sv ----
// package: register map, field layout, reset values and memory map of the control bank
package kbd_regs_pkg;
  localparam logic [15:0] addr_port_a_data = 16'h0000;
  localparam logic [15:0] addr_port_b_data = 16'h0001;
  localparam logic [15:0] addr_port_a_direction = 16'h0002;
  localparam logic [15:0] addr_port_b_direction = 16'h0003;
  localparam logic [15:0] addr_timer_control_status = 16'h0004;
  localparam logic [15:0] addr_timer_count = 16'h0005;
  localparam logic [15:0] addr_interrupt_control_status = 16'h0006;
  localparam logic [15:0] addr_watchdog_clear = 16'h0007;
  localparam logic [15:0] addr_sleep_control = 16'h0008;
  localparam logic [15:0] addr_port_a_pullup_off = 16'h0009;
  localparam logic [15:0] addr_port_b_pullup_off = 16'h000a;
  localparam logic [15:0] addr_port_c_pullup_off = 16'h000b;
  localparam logic [15:0] addr_port_c_data = 16'h000c;
  localparam logic [15:0] addr_port_c_direction = 16'h000d;
  localparam logic [15:0] addr_port_d_direction_status = 16'h0011;
  localparam logic [15:0] addr_port_d_output = 16'h0012;
  localparam logic [15:0] addr_port_d_pullup_off = 16'h0013;
  localparam logic [15:0] addr_port_e_direction = 16'h0014;
  localparam logic [15:0] addr_port_e_data = 16'h0015;
  localparam logic [15:0] addr_port_e_resistor_off = 16'h0016;
  localparam logic [15:0] addr_port_f_direction = 16'h0017;
  localparam logic [15:0] addr_port_f_data = 16'h0018;
  localparam logic [15:0] addr_port_f_pullup_off = 16'h0019;
  localparam logic [15:0] addr_func_last = 16'h0019;
  // memory map
  localparam logic [15:0] ram_base = 16'h0060;
  localparam logic [15:0] ram_top = 16'h00ff;
  localparam logic [15:0] stack_top = 16'h00ff;
  localparam logic [15:0] test_rom_base = 16'h0400;
  localparam logic [15:0] test_rom_top = 16'h05ff;
  localparam logic [15:0] user_rom_base = 16'h0600;
  localparam logic [15:0] user_rom_top = 16'h1fff;
  localparam logic [15:0] vector_nmi = 16'h1ffa;
  localparam logic [15:0] vector_reset = 16'h1ffc;
  localparam logic [15:0] vector_irq = 16'h1ffe;
  localparam int ram_bytes = 160;
  localparam int user_rom_bytes = 6656;
  localparam int test_rom_bytes = 512;
  // timer control/status field positions
  localparam int tcs_overflow_flag = 7;
  localparam int tcs_rt_flag = 6;
  localparam int tcs_overflow_enable = 5;
  localparam int tcs_rt_enable = 4;
  localparam int tcs_overflow_clear = 3;
  localparam int tcs_rt_clear = 2;
  localparam int tcs_rate_high = 1;
  localparam int tcs_rate_low = 0;
  localparam logic [7:0] tcs_rw_mask = 8'h33;
  localparam logic [7:0] tcs_reset = 8'h03;
  localparam logic [7:0] zero_byte = 8'h00;
  localparam logic [7:0] irq_rw_mask = 8'h11;
  localparam logic [7:0] low_nibble = 8'h0f;
  localparam logic [7:0] port_d_out_mask = 8'h3f;
  localparam logic [7:0] wdt_mask = 8'h01;
  localparam logic [7:0] stop_mask = 8'h10;
  // clock source choice, fixed at build time
  typedef enum logic [1:0] {
    clk_crystal = 2'b00,
    clk_rc = 2'b01,
    clk_external = 2'b11
  } clock_source_type;
  // decoded region of a processor address
  typedef enum logic [2:0] {
    region_func = 3'b000,
    region_ram = 3'b001,
    region_test_rom = 3'b011,
    region_user_rom = 3'b010,
    region_vector = 3'b110,
    region_none = 3'b111
  } region_type;
  // processor bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;
  // pad group of one 8-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_en;
  } pad_ctl_type;
endpackage : kbd_regs_pkg

// ---- rtl/addr_decoder.sv ----
// address decoder: classifies a processor address into memory regions
`timescale 1ns/1ps
module addr_decoder
  import kbd_regs_pkg::*;
(
  input wire logic [15:0] addr, // processor address
  output region_type region, // decoded region
  output logic [7:0] ram_index // offset inside ram
);
  // vectors sit inside user rom; they are flagged first so fetch logic can see them
  always_comb begin
    ram_index = 8'h00;
    if (addr <= addr_func_last) begin
      region = region_func;
    end else if (addr >= ram_base && addr <= ram_top) begin
      region = region_ram;
      ram_index = 8'(addr - ram_base);
    end else if (addr >= test_rom_base && addr <= test_rom_top) begin
      region = region_test_rom;
    end else if (addr >= vector_nmi && addr <= user_rom_top) begin
      region = region_vector;
    end else if (addr >= user_rom_base && addr <= user_rom_top) begin
      region = region_user_rom;
    end else begin
      region = region_none;
    end
  end
endmodule : addr_decoder

// ---- rtl/port_cell.sv ----
// one gpio port: data, direction and pull control with read-back mux
`timescale 1ns/1ps
module port_cell
  import kbd_regs_pkg::*;
#(
  parameter int width = 8, // pads in this port
  parameter bit open_drain = 1'b1 // build-time pad style
) (
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset
  input wire logic data_we, // write data register
  input wire logic dir_we, // write direction register
  input wire logic pull_we, // write pull control register
  input wire logic [width-1:0] wdata, // write data
  input wire logic [width-1:0] pad_in, // pad levels
  output logic [width-1:0] rdata, // read-back value
  output logic [width-1:0] pad_out, // pad output value
  output logic [width-1:0] pad_oe, // pad output enable
  output logic [width-1:0] pull_en // pull resistor on
);
  logic [width-1:0] data_q;
  logic [width-1:0] dir_q;
  logic [width-1:0] pull_off_q;

  // data register
  always_ff @(posedge clk_sys) begin
    if (srst) data_q <= '0;
    else if (data_we) data_q <= wdata;
  end

  // direction register, write-only
  always_ff @(posedge clk_sys) begin
    if (srst) dir_q <= '0;
    else if (dir_we) dir_q <= wdata;
  end

  // pull control, write-only, one means off
  always_ff @(posedge clk_sys) begin
    if (srst) pull_off_q <= '0;
    else if (pull_we) pull_off_q <= wdata;
  end

  // outputs read stored data, inputs read the pad
  assign rdata = (dir_q & data_q) | (~dir_q & pad_in);
  // open-drain: zero pulls low, one releases the pad
  assign pad_out = open_drain ? '0 : data_q;
  assign pad_oe = open_drain ? (dir_q & ~data_q) : dir_q;
  // pulls only matter in input mode
  assign pull_en = ~pull_off_q & ~dir_q;

  chk_input_readback: assert property (@(posedge clk_sys) disable iff (srst)
    (dir_q == '0) |-> (rdata == pad_in)) else $error("input bits must read pad level");
  chk_open_drain_low: assert property (@(posedge clk_sys) disable iff (srst)
    (open_drain && dir_q[0] && !data_q[0]) |-> (pad_oe[0] && !pad_out[0]))
    else $error("open-drain zero must drive low");
endmodule : port_cell

// ---- rtl/kbd_ctrl_regs.sv ----
// control register bank and address map of the keyboard controller
// Summary of operation
// - reset clears every function register except both rate-select bits, set to one
// - direction bit zero is input, one output; direction registers write-only
// - pull-up control zero enables, one disables; write-only
// - ram of 160 bytes at 0x60-0xff, stack grows down from 0xff
// - user rom 0x0600-0x1fff, test rom 0x0400-0x05ff
// - vectors at 0x1ffa-0x1fff: nmi, reset, irq; nmi source absent
// - timer control: flags ro, enables rw, clears wo, rate selects rw
// - timer count readable at 0x05, passed through live from timer_value, not reset by the bank
// - port d register: status bits 7-4 read, direction bits 3-0 write
// - port e resistor control four bits write-only, zero enables
// - mask options are build-time parameters, not software visible
// - exactly one clock source chosen at build time from three
// - data read returns stored bit for outputs, pad level for inputs
// - open-drain output: zero drives low, one releases pad
`timescale 1ns/1ps
module kbd_ctrl_regs
  import kbd_regs_pkg::*;
#(
  parameter clock_source_type clock_source = clk_crystal, // build-time oscillator choice
  parameter bit port_b_high_open_drain = 1'b1, // build-time style of port b 7:4
  parameter int ram_depth = ram_bytes // ram size in bytes
) (
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset
  input bus_req_type bus_req, // processor request
  output logic [7:0] rdata, // read data, registered
  output region_type region, // decoded region of current address
  output logic rom_select, // rom or vector region addressed
  output logic vector_fetch, // vector region addressed
  input wire logic [7:0] timer_value, // live timer count
  input wire logic timer_overflow_event, // timer overflow pulse
  input wire logic timer_rt_event, // real-time tick pulse
  input wire logic [3:0] port_d_status, // status bits for port d read
  input wire logic [3:0] irq_flags, // interrupt flags from irq logic
  output logic [7:0] timer_ctl, // timer control/status image
  output logic [7:0] irq_ctl, // interrupt enables
  output logic watchdog_clear_pulse, // watchdog clear strobe
  output logic stop_request, // stop request strobe
  output logic [1:0] clock_source_sel, // fixed oscillator selection
  input wire logic [7:0] pa_in, // port a pads
  input wire logic [7:0] pb_in, // port b pads
  input wire logic [7:0] pc_in, // port c pads
  input wire logic [7:0] pe_in, // port e pads (low four used)
  input wire logic [7:0] pf_in, // port f pads
  output pad_ctl_type pa_pad, // port a pad controls
  output pad_ctl_type pb_pad, // port b pad controls
  output pad_ctl_type pc_pad, // port c pad controls
  output pad_ctl_type pe_pad, // port e pad controls
  output pad_ctl_type pf_pad, // port f pad controls
  output logic [3:0] pd_out, // port d output data
  output logic [3:0] pd_oe, // port d output enable
  output logic [3:0] pd_pull_en, // port d pull enable
  output logic [1:0] status_select // status select field of port d output
);
  logic [7:0] ram [ram_depth];
  logic [7:0] ram_index;
  logic [7:0] next_rdata;
  logic [7:0] tcs;
  logic [7:0] irq_en;
  logic [5:0] pd_reg;
  logic [3:0] pd_dir;
  logic [3:0] pd_pull_off;
  logic [7:0] pb_pull_raw, pb_od_mask;
  logic wr_func;
  logic [7:0] pa_rd, pb_rd, pc_rd, pe_rd, pf_rd;
  logic [7:0] pb_oe_raw, pb_out_raw;

  addr_decoder u_dec (
    .addr(bus_req.addr),
    .region(region),
    .ram_index(ram_index)
  );

  assign rom_select = (region == region_user_rom) || (region == region_vector)
    || (region == region_test_rom);
  assign vector_fetch = (region == region_vector);
  assign wr_func = bus_req.wr && (region == region_func);
  // oscillator choice is frozen at build time, software cannot reach it
  assign clock_source_sel = clock_source;

  port_cell #(.width(8), .open_drain(1'b1)) u_pa (
    .clk_sys(clk_sys), .srst(srst),
    .data_we(wr_func && bus_req.addr == addr_port_a_data),
    .dir_we(wr_func && bus_req.addr == addr_port_a_direction),
    .pull_we(wr_func && bus_req.addr == addr_port_a_pullup_off),
    .wdata(bus_req.wdata), .pad_in(pa_in), .rdata(pa_rd),
    .pad_out(pa_pad.out), .pad_oe(pa_pad.oe), .pull_en(pa_pad.pull_en)
  );
  // port b cell runs push-pull; the masking below makes 3:0, and 7:4 by option, open drain
  port_cell #(.width(8), .open_drain(1'b0)) u_pb (
    .clk_sys(clk_sys), .srst(srst),
    .data_we(wr_func && bus_req.addr == addr_port_b_data),
    .dir_we(wr_func && bus_req.addr == addr_port_b_direction),
    .pull_we(wr_func && bus_req.addr == addr_port_b_pullup_off),
    .wdata(bus_req.wdata), .pad_in(pb_in), .rdata(pb_rd),
    .pad_out(pb_out_raw), .pad_oe(pb_oe_raw), .pull_en(pb_pull_raw)
  );
  port_cell #(.width(8), .open_drain(1'b1)) u_pc (
    .clk_sys(clk_sys), .srst(srst),
    .data_we(wr_func && bus_req.addr == addr_port_c_data),
    .dir_we(wr_func && bus_req.addr == addr_port_c_direction),
    .pull_we(wr_func && bus_req.addr == addr_port_c_pullup_off),
    .wdata(bus_req.wdata), .pad_in(pc_in), .rdata(pc_rd),
    .pad_out(pc_pad.out), .pad_oe(pc_pad.oe), .pull_en(pc_pad.pull_en)
  );
  port_cell #(.width(8), .open_drain(1'b1)) u_pe (
    .clk_sys(clk_sys), .srst(srst),
    .data_we(wr_func && bus_req.addr == addr_port_e_data),
    .dir_we(wr_func && bus_req.addr == addr_port_e_direction),
    .pull_we(wr_func && bus_req.addr == addr_port_e_resistor_off),
    .wdata(bus_req.wdata & low_nibble), .pad_in(pe_in & low_nibble), .rdata(pe_rd),
    .pad_out(pe_pad.out), .pad_oe(pe_pad.oe), .pull_en(pe_pad.pull_en)
  );
  port_cell #(.width(8), .open_drain(1'b1)) u_pf (
    .clk_sys(clk_sys), .srst(srst),
    .data_we(wr_func && bus_req.addr == addr_port_f_data),
    .dir_we(wr_func && bus_req.addr == addr_port_f_direction),
    .pull_we(wr_func && bus_req.addr == addr_port_f_pullup_off),
    .wdata(bus_req.wdata), .pad_in(pf_in), .rdata(pf_rd),
    .pad_out(pf_pad.out), .pad_oe(pf_pad.oe), .pull_en(pf_pad.pull_en)
  );

  // open-drain bits only pull low; totem-pole bits of 7:4 also drive a one high
  assign pb_od_mask = port_b_high_open_drain ? '1 : low_nibble;
  // one process owns the whole pad struct so it has a single driver
  always_comb begin
    pb_pad.out = pb_out_raw & ~pb_od_mask;
    pb_pad.oe = pb_oe_raw & ~(pb_od_mask & pb_out_raw);
    pb_pad.pull_en = pb_pull_raw;
  end

  // timer control: flags set by hardware, cleared by writing one to the clear bits
  // a set arriving with its clear wins so no overflow is lost
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tcs <= tcs_reset;
    end else begin
      if (wr_func && bus_req.addr == addr_timer_control_status) begin
        tcs <= (tcs & ~tcs_rw_mask) | (bus_req.wdata & tcs_rw_mask);
        if (bus_req.wdata[tcs_overflow_clear]) tcs[tcs_overflow_flag] <= 1'b0;
        if (bus_req.wdata[tcs_rt_clear]) tcs[tcs_rt_flag] <= 1'b0;
      end
      if (timer_overflow_event) tcs[tcs_overflow_flag] <= 1'b1;
      if (timer_rt_event) tcs[tcs_rt_flag] <= 1'b1;
      tcs[tcs_overflow_clear] <= 1'b0;
      tcs[tcs_rt_clear] <= 1'b0;
    end
  end
  assign timer_ctl = tcs;

  // interrupt enables
  always_ff @(posedge clk_sys) begin
    if (srst) irq_en <= zero_byte;
    else if (wr_func && bus_req.addr == addr_interrupt_control_status)
      irq_en <= bus_req.wdata & irq_rw_mask;
  end
  assign irq_ctl = irq_en;

  // watchdog clear and stop are strobes; nothing is stored
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      watchdog_clear_pulse <= 1'b0;
      stop_request <= 1'b0;
    end else begin
      watchdog_clear_pulse <= wr_func && bus_req.addr == addr_watchdog_clear
        && |(bus_req.wdata & wdt_mask);
      stop_request <= wr_func && bus_req.addr == addr_sleep_control
        && |(bus_req.wdata & stop_mask);
    end
  end

  // port d: direction write-only in low nibble, output data plus status select
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pd_dir <= 4'h0;
      pd_reg <= 6'h00;
      pd_pull_off <= 4'h0;
    end else begin
      if (wr_func && bus_req.addr == addr_port_d_direction_status)
        pd_dir <= bus_req.wdata[3:0];
      if (wr_func && bus_req.addr == addr_port_d_output)
        pd_reg <= bus_req.wdata[5:0];
      if (wr_func && bus_req.addr == addr_port_d_pullup_off)
        pd_pull_off <= bus_req.wdata[3:0];
    end
  end
  // led outputs drive both levels
  assign pd_out = pd_reg[3:0];
  assign pd_oe = pd_dir;
  assign pd_pull_en = ~pd_pull_off & ~pd_dir;
  assign status_select = pd_reg[5:4];

  // ram, stack lives at its top and grows downward under processor control
  always_ff @(posedge clk_sys) begin
    if (bus_req.wr && region == region_ram) ram[ram_index] <= bus_req.wdata;
  end

  // read mux; write-only and reserved bits read zero
  always_comb begin
    next_rdata = zero_byte;
    if (region == region_ram) begin
      next_rdata = ram[ram_index];
    end else if (region == region_func) begin
      case (bus_req.addr)
        addr_port_a_data: next_rdata = pa_rd;
        addr_port_b_data: next_rdata = pb_rd;
        addr_timer_control_status: next_rdata = tcs & ~(8'h0c);
        addr_timer_count: next_rdata = timer_value;
        addr_interrupt_control_status: next_rdata = {3'h0, irq_en[4], irq_flags[3:2],
          irq_flags[1], irq_en[0]} & 8'h3b;
        addr_port_c_data: next_rdata = pc_rd;
        addr_port_d_direction_status: next_rdata = {port_d_status, 4'h0};
        addr_port_d_output: next_rdata = {4'h0, pd_reg[3:0]};
        addr_port_e_data: next_rdata = pe_rd & low_nibble;
        addr_port_f_data: next_rdata = pf_rd;
        default: next_rdata = zero_byte;
      endcase
    end
  end

  // read data is registered, valid the cycle after the read
  always_ff @(posedge clk_sys) begin
    if (srst) rdata <= zero_byte;
    else if (bus_req.rd) rdata <= next_rdata;
    else rdata <= zero_byte;
  end

  chk_rate_reset: assert property (@(posedge clk_sys)
    $past(srst) |-> (tcs == tcs_reset)) else $error("timer control reset value wrong");
  chk_flag_set_wins: assert property (@(posedge clk_sys) disable iff (srst)
    timer_overflow_event |=> tcs[tcs_overflow_flag]) else $error("overflow flag lost");
  chk_clear_bits_zero: assert property (@(posedge clk_sys) disable iff (srst)
    ##1 (tcs[tcs_overflow_clear] == 1'b0 && tcs[tcs_rt_clear] == 1'b0))
    else $error("clear bits must not stay set");
  chk_count_read: assert property (@(posedge clk_sys) disable iff (srst)
    (bus_req.rd && bus_req.addr == addr_timer_count) |=> (rdata == $past(timer_value)))
    else $error("timer count read wrong");
  chk_pd_status_read: assert property (@(posedge clk_sys) disable iff (srst)
    (bus_req.rd && bus_req.addr == addr_port_d_direction_status)
    |=> (rdata == {$past(port_d_status), 4'h0})) else $error("port d status read wrong");
  chk_dir_wo_read: assert property (@(posedge clk_sys) disable iff (srst)
    (bus_req.rd && (bus_req.addr == addr_port_a_direction
    || bus_req.addr == addr_port_e_resistor_off)) |=> (rdata == zero_byte))
    else $error("write-only register read nonzero");
  chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (srst)
    (bus_req.rd && bus_req.addr == 16'h000e) |=> (rdata == zero_byte))
    else $error("unassigned address read nonzero");
  chk_vector_region: assert property (@(posedge clk_sys) disable iff (srst)
    (bus_req.addr >= vector_nmi && bus_req.addr <= user_rom_top) |-> (vector_fetch && rom_select))
    else $error("vector region not decoded");
  chk_ram_region: assert property (@(posedge clk_sys) disable iff (srst)
    (bus_req.addr >= ram_base && bus_req.addr <= stack_top) |-> (region == region_ram))
    else $error("ram region not decoded");
endmodule : kbd_ctrl_regs

// ---- verif/cpu_bus_model.sv ----
// processor core model: byte writes, byte reads and bare address cycles on the internal bus
`timescale 1ns/1ps
module cpu_bus_model
  import kbd_regs_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic [7:0] rdata, // read data from the bank
  output bus_req_type bus_req // bus request
);
  initial begin
    bus_req = '0;
  end
  // one strobe edge; afterwards address and data are inverted so no stale value looks valid
  task automatic write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : write
  // read data stands for the one cycle after the taking edge
  task automatic read(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    #1;
    d = rdata;
  endtask : read
  // address only, no strobe, for looking at the decoder
  task automatic show_addr(input logic [15:0] a);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1;
  endtask : show_addr
endmodule : cpu_bus_model

// ---- verif/keyboard_mcu_control_register_bank_tb_top.sv ----
// self-checking bench of the keyboard controller register bank
`timescale 1ns/1ps
module keyboard_mcu_control_register_bank_tb_top
  import kbd_regs_pkg::*;
;
  logic clk_sys, srst, ovf_ev, rt_ev;
  logic [7:0] timer_value, ext_a, ext_e, rdata, d;
  logic [3:0] port_d_status, irq_flags, pd_out, pd_oe, pd_pull_en;
  logic [7:0] pa_in, pb_in, pc_in, pe_in, pf_in, timer_ctl, irq_ctl;
  logic rom_select, vector_fetch, wdt_pulse, stop_req;
  logic [1:0] clock_source_sel, ssel;
  region_type region;
  bus_req_type bus_req;
  pad_ctl_type pa_pad, pb_pad, pc_pad, pe_pad, pf_pad;
  int bad_count = 0;
  int num_checks = 0;
  // pad wires: a driven pad follows the bank, a released one the outside level on ports a and e, zero on b, c and f
  assign pa_in = (pa_pad.oe & pa_pad.out) | (~pa_pad.oe & ext_a);
  assign pb_in = pb_pad.oe & pb_pad.out;
  assign pc_in = pc_pad.oe & pc_pad.out;
  assign pe_in = (pe_pad.oe & pe_pad.out) | (~pe_pad.oe & ext_e);
  assign pf_in = pf_pad.oe & pf_pad.out;
  cpu_bus_model u_cpu (.clk_sys(clk_sys), .rdata(rdata), .bus_req(bus_req));
  kbd_ctrl_regs #(.clock_source(clk_rc)) u_dut (.clk_sys(clk_sys), .srst(srst),
    .bus_req(bus_req), .rdata(rdata), .region(region), .rom_select(rom_select),
    .vector_fetch(vector_fetch), .timer_value(timer_value), .timer_overflow_event(ovf_ev),
    .timer_rt_event(rt_ev), .port_d_status(port_d_status), .irq_flags(irq_flags),
    .timer_ctl(timer_ctl), .irq_ctl(irq_ctl), .watchdog_clear_pulse(wdt_pulse),
    .stop_request(stop_req), .clock_source_sel(clock_source_sel), .pa_in(pa_in), .pb_in(pb_in),
    .pc_in(pc_in), .pe_in(pe_in), .pf_in(pf_in), .pa_pad(pa_pad), .pb_pad(pb_pad),
    .pc_pad(pc_pad), .pe_pad(pe_pad), .pf_pad(pf_pad), .pd_out(pd_out), .pd_oe(pd_oe),
    .pd_pull_en(pd_pull_en), .status_select(ssel));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic do_reset(input int n);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (n) @(posedge clk_sys);
    srst <= 1'b0;
  endtask : do_reset
  // reset image, write-only and unassigned places read as zero
  task automatic test_reset();
    u_cpu.read(addr_timer_control_status, d);
    check("timer control", 8'h03, d);
    check("timer_ctl port", 8'h03, timer_ctl);
    check("port a oe", 8'h00, pa_pad.oe);
    check("port a pull", 8'hff, pa_pad.pull_en);
    u_cpu.read(addr_timer_count, d);
    check("timer count", timer_value, d);
    u_cpu.read(addr_port_a_direction, d);
    check("direction read", 8'h00, d);
    u_cpu.read(16'h000e, d);
    check("unassigned read", 8'h00, d);
    $display("test reset done");
  endtask : test_reset
  // mixed direction: outputs read stored data, inputs read the pad
  task automatic test_port_a();
    u_cpu.write(addr_port_a_direction, 8'hf0);
    u_cpu.write(addr_port_a_data, 8'h3c);
    #1;
    check("port a oe", 8'hc0, pa_pad.oe);
    check("port a out low", 8'h00, pa_pad.out & pa_pad.oe);
    u_cpu.read(addr_port_a_data, d);
    check("port a read", 8'h35, d);
    u_cpu.write(addr_port_a_direction, 8'h00);
    u_cpu.write(addr_port_a_pullup_off, 8'h0f);
    #1;
    check("port a pull", 8'hf0, pa_pad.pull_en);
    u_cpu.write(addr_port_c_direction, 8'h0f);
    #1;
    check("port c oe", 8'h0f, pc_pad.oe);
    u_cpu.write(addr_port_e_resistor_off, 8'h05);
    #1;
    check("port e pull", 8'h0a, {4'h0, pe_pad.pull_en[3:0]});
    $display("test port a done");
  endtask : test_port_a
  // access kinds of the timer byte, flag set and clear, plus the strobes
  task automatic test_timer();
    u_cpu.write(addr_timer_control_status, 8'hff);
    u_cpu.read(addr_timer_control_status, d);
    check("timer control", 8'h33, d);
    @(posedge clk_sys);
    ovf_ev <= 1'b1;
    rt_ev <= 1'b1;
    @(posedge clk_sys);
    ovf_ev <= 1'b0;
    rt_ev <= 1'b0;
    u_cpu.read(addr_timer_control_status, d);
    check("flags set", 8'hf3, d);
    u_cpu.write(addr_timer_control_status, 8'h08);
    u_cpu.read(addr_timer_control_status, d);
    check("overflow clear", 8'h40, d);
    // a new overflow in the clearing cycle must survive the clear
    fork
      u_cpu.write(addr_timer_control_status, 8'h0c);
      begin
        @(posedge clk_sys);
        ovf_ev <= 1'b1;
        @(posedge clk_sys);
        ovf_ev <= 1'b0;
      end
    join
    u_cpu.read(addr_timer_control_status, d);
    check("set wins", 8'h80, d);
    u_cpu.write(addr_watchdog_clear, 8'h01);
    #1;
    check("watchdog pulse", 8'h01, {7'h0, wdt_pulse});
    u_cpu.write(addr_interrupt_control_status, 8'hff);
    u_cpu.read(addr_interrupt_control_status, d);
    check("irq control", 8'h11, d);
    check("irq_ctl port", 8'h11, irq_ctl);
    u_cpu.write(addr_sleep_control, 8'h10);
    #1;
    check("stop request", 8'h01, {7'h0, stop_req});
    check("clock source", {6'h0, clk_rc}, {6'h0, clock_source_sel});
    $display("test timer done");
  endtask : test_timer
  // port d: status bits readable, direction bits write-only
  task automatic test_port_d();
    @(posedge clk_sys);
    port_d_status <= 4'h9;
    u_cpu.write(addr_port_d_direction_status, 8'hf5);
    u_cpu.read(addr_port_d_direction_status, d);
    check("port d status", 8'h90, d);
    check("port d oe", 8'h05, {4'h0, pd_oe});
    u_cpu.write(addr_port_d_output, 8'h3a);
    u_cpu.write(addr_port_d_pullup_off, 8'h03);
    #1;
    check("port d out", 8'h3a, {2'h0, ssel, pd_out});
    check("port d pull", 8'h08, {4'h0, pd_pull_en});
    u_cpu.read(addr_port_d_output, d);
    check("port d read", 8'h0a, d);
    $display("test port d done");
  endtask : test_port_d
  // decoder boundaries of ram, both roms and the vectors
  task automatic test_map();
    logic [15:0] a [10];
    region_type r [10];
    a = '{16'h0000, 16'h0019, 16'h0060, 16'h00ff, 16'h0400,
          16'h05ff, 16'h0600, 16'h1ff9, 16'h1ffa, 16'h1fff};
    r = '{region_func, region_func, region_ram, region_ram, region_test_rom,
          region_test_rom, region_user_rom, region_user_rom, region_vector, region_vector};
    for (int i = 0; i < 10; i++) begin
      u_cpu.show_addr(a[i]);
      check("region", {5'h0, r[i]}, {5'h0, region});
      check("vector", {7'h0, r[i] == region_vector}, {7'h0, vector_fetch});
      check("rom", {7'h0, r[i] != region_func && r[i] != region_ram},
            {7'h0, rom_select});
    end
    u_cpu.write(ram_base, 8'h3c);
    u_cpu.write(stack_top, 8'hc3);
    u_cpu.read(ram_base, d);
    check("ram low", 8'h3c, d);
    u_cpu.read(stack_top, d);
    check("ram top", 8'hc3, d);
    $display("test map done");
  endtask : test_map
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  initial begin
    srst = 1'b1;
    ovf_ev = 1'b0;
    rt_ev = 1'b0;
    timer_value = 8'h5a;
    ext_a = 8'ha5;
    ext_e = 8'h0c;
    port_d_status = 4'h0;
    irq_flags = 4'h0;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    test_reset();
    test_port_a();
    test_timer();
    test_port_d();
    test_map();
    do_reset(2);
    test_reset();
    results();
  end
  // a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    results();
  end
endmodule : keyboard_mcu_control_register_bank_tb_top
